// File: hw/fpet_exception_unit.v
// Behaviour
// [RULE_01] Byte, word or long external operand adds three cycles.
// [RULE_02] Extended external operand adds two cycles, except multi-register moves.
// [RULE_03] Memory-indirect indexed mode adds two cycles and one read.
// [RULE_04] Double precision immediate operand adds one cycle, no bus access.
// [RULE_05] Accesses stay in program order; noncachable regions are serialized.
// [RULE_06] Change-of-flow trace encoding never raises a trace exception.
// [RULE_07] Branch cache uses logical index; a control register write with bit 22 set flushes it.
// [RULE_08] Class two special single/double source is saved unconverted.
// [RULE_09] Class three enabled SNaN/operand error skips default result write.
// [RULE_10] Inexact is pre-instruction for classes zero, two; post for three.
// [RULE_11] Inexact exception uses vector forty-nine.
// [RULE_12] Inexact state frame is valid with extended-converted source.
// [RULE_13] Disabled inexact trap: no exception, rounded result delivered.
// [RULE_14] System logic should block interrupts while locked transfer shows.
// [RULE_15] Saved frame records the causing instruction class.
`timescale 1ns/1ps
`include "fpet_consts.vh"

module fpet_exception_unit (
   input  wire          ref_clk,
   input  wire          rst,
   // Instruction issue
   input  wire          issueValid,
   input  wire [7:0]    baseCycles,
   input  wire [3:0]    baseReads,
   input  wire          extOperand,
   input  wire [2:0]    srcFormat,
   input  wire          multiRegMove,
   input  wire          memIndirect,
   input  wire          immOperand,
   // Completion and exception sources
   input  wire          doneValid,
   input  wire [1:0]    instrClass,
   input  wire          inexactCond,
   input  wire          inexactEnable,
   input  wire          snanCond,
   input  wire          snanEnable,
   input  wire          operrCond,
   input  wire          operrEnable,
   input  wire          srcSpecial,
   input  wire [79:0]   srcConverted,
   input  wire [79:0]   srcRaw,
   input  wire [79:0]   resultIn,
   // Trace
   input  wire          traceStep,
   input  wire [1:0]    traceMode,
   // Memory access ordering
   input  wire          accReq,
   input  wire [1:0]    cacheModeField,
   input  wire          accDone,
   // Branch cache
   input  wire          cacheControlWrite,
   input  wire [31:0]   cacheControlData,
   input  wire          bcFill,
   input  wire [31:0]   bcFillAddr,
   input  wire [31:0]   bcFillTarget,
   input  wire [31:0]   bcLookupAddr,
   // Outputs
   output reg  [7:0]    totalCycles_reg,
   output reg  [3:0]    totalReads_reg,
   output reg           timingValid_reg,
   output reg           excTake_reg,
   output reg           excPre_reg,
   output reg  [7:0]    excVector_reg,
   output reg           frameValid_reg,
   output reg  [1:0]    frameClass_reg,
   output reg  [79:0]   frameOperand_reg,
   output reg           resultWrite_reg,
   output reg  [79:0]   resultOut_reg,
   output reg           traceExc_reg,
   output reg           accGrant_reg,
   output reg           bcHit_reg,
   output reg  [31:0]   bcTarget_reg
);

   // ------------------------------------------------------------
   // Execution time adjustment
   // ------------------------------------------------------------
   wire fmtInteger = (srcFormat == `FPET_FMT_BYTE) | (srcFormat == `FPET_FMT_WORD)
                   | (srcFormat == `FPET_FMT_LONG);
   wire fmtExt     = (srcFormat == `FPET_FMT_EXTENDED);
   wire fmtDbl     = (srcFormat == `FPET_FMT_DOUBLE);

   wire [7:0] addInt  = (extOperand & fmtInteger) ? `FPET_ADD_INTEGER : 8'h00; // see [RULE_01]
   wire [7:0] addExt  = (extOperand & fmtExt & ~multiRegMove) ?
                        `FPET_ADD_EXTENDED : 8'h00;                           // see [RULE_02]
   wire [7:0] addInd  = memIndirect ? `FPET_ADD_MEMIND : 8'h00;               // see [RULE_03]
   wire [3:0] addRd   = memIndirect ? `FPET_ADD_MEMIND_RD : 4'h0;             // see [RULE_03]
   wire [7:0] addImm  = (immOperand & fmtDbl) ? `FPET_ADD_DBL_IMM : 8'h00;   // see [RULE_04]

   wire [7:0] cyclesNext = baseCycles + addInt + addExt + addInd + addImm;
   wire [3:0] readsNext  = baseReads + addRd;

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         totalCycles_reg <= 8'h00;
         totalReads_reg  <= 4'h0;
         timingValid_reg <= 1'b0;
      end else begin
         timingValid_reg <= issueValid;
         if (issueValid) begin
            totalCycles_reg <= cyclesNext;
            totalReads_reg  <= readsNext;
         end
      end
   end

   // ------------------------------------------------------------
   // Exception selection and state frame
   // ------------------------------------------------------------
   // Enabled SNaN/operand error outrank inexact, matching the usual priority
   wire snanTrap  = snanCond & snanEnable;
   wire operrTrap = operrCond & operrEnable;
   wire inexTrap  = inexactCond & inexactEnable;          // see [RULE_13]
   wire isPost    = (instrClass == `FPET_CLASS_THREE);
   wire anyTrap   = snanTrap | operrTrap | inexTrap;

   reg [7:0]  vecNext;
   reg [79:0] frameOpNext;
   always @* begin
      vecNext     = `FPET_VEC_NONE;
      frameOpNext = srcConverted;
      if (snanTrap) begin
         vecNext = `FPET_VEC_SNAN;
      end else if (operrTrap) begin
         vecNext = `FPET_VEC_OPERR;
      end else if (inexTrap) begin
         vecNext = `FPET_VEC_INEXACT;                      // see [RULE_11]
      end
      // Special single/double sources are left for the handler to convert
      if ((snanTrap | operrTrap) & (instrClass == `FPET_CLASS_TWO) & srcSpecial &
          ((srcFormat == `FPET_FMT_SINGLE) | fmtDbl)) begin
         frameOpNext = srcRaw;                             // see [RULE_08]
      end
   end

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         excTake_reg      <= 1'b0;
         excPre_reg       <= 1'b0;
         excVector_reg    <= `FPET_VEC_NONE;
         frameValid_reg   <= 1'b0;
         frameClass_reg   <= `FPET_CLASS_ZERO;
         frameOperand_reg <= 80'h0;
         resultWrite_reg  <= 1'b0;
         resultOut_reg    <= 80'h0;
      end else begin
         excTake_reg     <= doneValid & anyTrap;
         // Post-instruction traps still skip the write when SNaN/operr are enabled
         resultWrite_reg <= doneValid & isPost & ~snanTrap & ~operrTrap; // see [RULE_09]
         if (doneValid) begin
            resultOut_reg <= resultIn;                     // see [RULE_13]
         end
         if (doneValid & anyTrap) begin
            excPre_reg       <= ~isPost;                   // see [RULE_10]
            excVector_reg    <= vecNext;
            frameValid_reg   <= 1'b1;                      // see [RULE_12]
            frameClass_reg   <= instrClass;                // see [RULE_15]
            frameOperand_reg <= frameOpNext;               // see [RULE_12]
         end
      end
   end

   // ------------------------------------------------------------
   // Trace
   // ------------------------------------------------------------
   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         traceExc_reg <= 1'b0;
      end else begin
         traceExc_reg <= traceStep & (traceMode == `FPET_TRACE_ALL); // see [RULE_06]
      end
   end

   // ------------------------------------------------------------
   // Memory access ordering
   // ------------------------------------------------------------
   // One access in flight at a time keeps strict program order; a
   // noncachable access additionally waits for the previous to retire.
   reg busy_reg;
   wire ncAccess = (cacheModeField == `FPET_CM_NC_PRECISE) |
                   (cacheModeField == `FPET_CM_NC_IMPREC);
   wire grantNow = accReq & (~busy_reg | accDone) & ~(ncAccess & busy_reg);

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         busy_reg     <= 1'b0;
         accGrant_reg <= 1'b0;
      end else begin
         accGrant_reg <= grantNow;                         // see [RULE_05]
         if (grantNow) begin
            busy_reg <= 1'b1;
         end else if (accDone) begin
            busy_reg <= 1'b0;
         end
      end
   end

   // ------------------------------------------------------------
   // Branch cache
   // ------------------------------------------------------------
   // One bit of the cache control write requests a branch cache clear
   wire bcFlush = cacheControlWrite & cacheControlData[`FPET_BC_FLUSH_BIT]; // see [RULE_07]

   wire [`FPET_BC_IDX_W-1:0] fillIdx =
      bcFillAddr[`FPET_BC_IDX_LO + `FPET_BC_IDX_W - 1:`FPET_BC_IDX_LO];
   wire [`FPET_BC_IDX_W-1:0] lookIdx =
      bcLookupAddr[`FPET_BC_IDX_LO + `FPET_BC_IDX_W - 1:`FPET_BC_IDX_LO];

   wire [`FPET_BC_ENTRIES-1:0]                 entValid;
   wire [`FPET_BC_ENTRIES*`FPET_BC_TAG_W-1:0]  entTag;
   wire [`FPET_BC_ENTRIES*32-1:0]              entTarget;

   genvar g;
   generate
      for (g = 0; g < `FPET_BC_ENTRIES; g = g + 1) begin : bcEntry
         fpet_branch_entry uEntry (
            .ref_clk     (ref_clk),
            .rst         (rst),
            .flush       (bcFlush),
            .writeEn     (bcFill & (fillIdx == g)),
            .writeTag    (bcFillAddr[31:32-`FPET_BC_TAG_W]),
            .writeTarget (bcFillTarget),
            .valid_reg   (entValid[g]),
            .tag_reg     (entTag[g*`FPET_BC_TAG_W +: `FPET_BC_TAG_W]),
            .target_reg  (entTarget[g*32 +: 32])
         );
      end
   endgenerate

   wire lookHit = entValid[lookIdx] &
      (entTag[lookIdx*`FPET_BC_TAG_W +: `FPET_BC_TAG_W] ==
       bcLookupAddr[31:32-`FPET_BC_TAG_W]);

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         bcHit_reg    <= 1'b0;
         bcTarget_reg <= 32'h0;
      end else begin
         bcHit_reg    <= lookHit & ~bcFlush;
         bcTarget_reg <= entTarget[lookIdx*32 +: 32];
      end
   end

endmodule

// File: hw/fpet_consts.vh
`ifndef FPET_CONSTS_VH
`define FPET_CONSTS_VH

// ------------------------------------------------------------
// Operand formats
// ------------------------------------------------------------
`define FPET_FMT_LONG      3'h0
`define FPET_FMT_SINGLE    3'h1
`define FPET_FMT_EXTENDED  3'h2
`define FPET_FMT_PACKED    3'h3
`define FPET_FMT_WORD      3'h4
`define FPET_FMT_DOUBLE    3'h5
`define FPET_FMT_BYTE      3'h6

// ------------------------------------------------------------
// Extra cycle and read counts
// ------------------------------------------------------------
`define FPET_ADD_INTEGER   8'h03
`define FPET_ADD_EXTENDED  8'h02
`define FPET_ADD_MEMIND    8'h02
`define FPET_ADD_MEMIND_RD 4'h1
`define FPET_ADD_DBL_IMM   8'h01

// ------------------------------------------------------------
// Instruction classes, vectors, trace and cache modes
// ------------------------------------------------------------
`define FPET_CLASS_ZERO    2'h0
`define FPET_CLASS_TWO     2'h2
`define FPET_CLASS_THREE   2'h3
`define FPET_VEC_INEXACT   8'h31
`define FPET_VEC_SNAN      8'h36
`define FPET_VEC_OPERR     8'h34
`define FPET_VEC_NONE      8'h00
`define FPET_TRACE_FLOW    2'h1
`define FPET_TRACE_ALL     2'h2
`define FPET_CM_NC_PRECISE 2'h2
`define FPET_CM_NC_IMPREC  2'h3

// ------------------------------------------------------------
// Branch cache geometry
// ------------------------------------------------------------
`define FPET_BC_IDX_W      4
`define FPET_BC_IDX_LO     2
`define FPET_BC_ENTRIES    16
`define FPET_BC_TAG_W      26
`define FPET_BC_FLUSH_BIT  22

`endif

// File: hw/fpet_branch_entry.v
`timescale 1ns/1ps
`include "fpet_consts.vh"

// One branch cache entry, indexed by logical address bits only
module fpet_branch_entry (
   input  wire                         ref_clk,
   input  wire                         rst,
   input  wire                         flush,
   input  wire                         writeEn,
   input  wire [`FPET_BC_TAG_W-1:0]    writeTag,
   input  wire [31:0]                  writeTarget,
   output reg                          valid_reg,
   output reg  [`FPET_BC_TAG_W-1:0]    tag_reg,
   output reg  [31:0]                  target_reg
);

   always @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         valid_reg  <= 1'b0;
         tag_reg    <= {`FPET_BC_TAG_W{1'b0}};
         target_reg <= 32'h0;
      end else if (flush) begin
         // Flush beats a same-cycle fill so stale aliases never survive
         valid_reg  <= 1'b0; // see [RULE_07]
      end else if (writeEn) begin
         valid_reg  <= 1'b1;
         tag_reg    <= writeTag;
         target_reg <= writeTarget;
      end
   end

endmodule

// File: verification/fpet_exception_unit_asserts.sv
`timescale 1ns/1ps
module fpet_exception_unit_chk (
   input wire logic        ref_clk,
   input wire logic        rst,
   input wire logic        issueValid,
   input wire logic        extOperand,
   input wire logic        multiRegMove,
   input wire logic        memIndirect,
   input wire logic        immOperand,
   input wire logic        doneValid,
   input wire logic        inexactCond,
   input wire logic        inexactEnable,
   input wire logic        snanCond,
   input wire logic        snanEnable,
   input wire logic        operrCond,
   input wire logic        operrEnable,
   input wire logic        traceStep,
   input wire logic        timingValid_reg,
   input wire logic        excTake_reg,
   input wire logic        excPre_reg,
   input wire logic        resultWrite_reg,
   input wire logic        traceExc_reg,
   input wire logic [7:0]  baseCycles,
   input wire logic [7:0]  totalCycles_reg,
   input wire logic [7:0]  excVector_reg,
   input wire logic [3:0]  baseReads,
   input wire logic [3:0]  totalReads_reg,
   input wire logic [2:0]  srcFormat,
   input wire logic [1:0]  instrClass,
   input wire logic [1:0]  traceMode,
   input wire logic [1:0]  frameClass_reg,
   input wire logic [79:0] srcConverted,
   input wire logic [79:0] frameOperand_reg
);
   // Operand-only issue, so each extra-cycle source is checked alone
   wire plain = issueValid & extOperand & ~memIndirect & ~immOperand;
   wire inE   = inexactCond & inexactEnable;
   wire snE   = snanCond & snanEnable;
   wire opE   = operrCond & operrEnable;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence sInexTrap;
      doneValid && inE && !snE && !opE;
   endsequence
   sequence sInexFrame;
      excTake_reg && excVector_reg == 8'h31 && frameOperand_reg == $past(srcConverted);
   endsequence
   AST_TIMING_VALID: assert property (issueValid |=> timingValid_reg)
      else $error("timing result not flagged after issue");
   AST_INT_EXTRA: assert property (plain && srcFormat inside {3'h0, 3'h4, 3'h6}
      |=> totalCycles_reg == $past(baseCycles) + 8'h03)
      else $error("integer operand time wrong");
   AST_EXT_EXTRA: assert property (plain && srcFormat == 3'h2 |=>
      totalCycles_reg == $past(baseCycles) + ($past(multiRegMove) ? 8'h00 : 8'h02))
      else $error("extended operand time wrong");
   AST_MEMIND: assert property (issueValid && memIndirect && !extOperand
      && !immOperand |=> totalCycles_reg == $past(baseCycles) + 8'h02
      && totalReads_reg == $past(baseReads) + 4'h1)
      else $error("memory indirect time wrong");
   AST_DBL_IMM: assert property (issueValid && immOperand && srcFormat == 3'h5
      && !memIndirect |=> totalCycles_reg == $past(baseCycles) + 8'h01
      && totalReads_reg == $past(baseReads))
      else $error("double immediate time wrong");
   AST_INEX_VEC: assert property (sInexTrap |=> sInexFrame)
      else $error("inexact vector or frame wrong");
   AST_INEX_PRE: assert property (sInexTrap |=>
      excPre_reg == ($past(instrClass) != 2'h3) && frameClass_reg == $past(instrClass))
      else $error("inexact timing class wrong");
   AST_MASKED: assert property (doneValid && !inE && !snE && !opE
      |=> !excTake_reg)
      else $error("exception taken with traps disabled");
   AST_NO_DEFAULT: assert property (doneValid && instrClass == 2'h3 && (snE|opE)
      |=> excTake_reg && !resultWrite_reg)
      else $error("default result written before trap");
   AST_FLOW_TRACE: assert property (traceStep && traceMode == 2'h1
      |=> !traceExc_reg)
      else $error("trace raised on change of flow");
endmodule
bind fpet_exception_unit fpet_exception_unit_chk u_fpet_exception_unit_chk (
   .ref_clk(ref_clk), .rst(rst), .issueValid(issueValid), .extOperand(extOperand),
   .multiRegMove(multiRegMove), .memIndirect(memIndirect), .immOperand(immOperand),
   .doneValid(doneValid), .inexactCond(inexactCond), .inexactEnable(inexactEnable),
   .snanCond(snanCond), .snanEnable(snanEnable), .operrCond(operrCond),
   .operrEnable(operrEnable), .traceStep(traceStep), .timingValid_reg(timingValid_reg),
   .excTake_reg(excTake_reg), .excPre_reg(excPre_reg), .resultWrite_reg(resultWrite_reg),
   .traceExc_reg(traceExc_reg), .baseCycles(baseCycles), .totalCycles_reg(totalCycles_reg),
   .excVector_reg(excVector_reg), .baseReads(baseReads), .totalReads_reg(totalReads_reg),
   .srcFormat(srcFormat), .instrClass(instrClass), .traceMode(traceMode),
   .frameClass_reg(frameClass_reg), .srcConverted(srcConverted),
   .frameOperand_reg(frameOperand_reg)
);

// File: verification/fpet_exception_unit_tb.sv
`timescale 1ns/1ps
module fpet_exception_unit_tb;
   logic        ref_clk = 0, rst = 1, issueValid = 0, extOperand = 0, multiRegMove = 0;
   logic        memIndirect = 0, immOperand = 0, doneValid = 0, inexactCond = 0;
   logic        inexactEnable = 0, snanCond = 0, snanEnable = 0, operrCond = 0, operrEnable = 0;
   logic        srcSpecial = 0, traceStep = 0, accReq = 0, accDone = 0;
   logic        cacheControlWrite = 0, bcFill = 0;
   logic [7:0]  baseCycles = 8'h10;
   logic [3:0]  baseReads = 4'h1;
   logic [2:0]  srcFormat = 3'h0;
   logic [1:0]  instrClass = 2'h0, traceMode = 2'h0, cacheModeField = 2'h0;
   logic [79:0] srcConverted = 80'haaaa_0000_1111_2222_3333, srcRaw = 80'h5555_4444_6666_7777_8888;
   logic [79:0] resultIn = 80'h1234_5678_9abc_def0_0f0f;
   logic [31:0] cacheControlData = 32'h0, bcFillAddr = 32'h0, bcFillTarget = 32'h0;
   logic [31:0] bcLookupAddr = 32'h0;
   wire  [7:0]  totalCycles_reg, excVector_reg;
   wire  [3:0]  totalReads_reg;
   wire  [1:0]  frameClass_reg;
   wire  [79:0] frameOperand_reg, resultOut_reg;
   wire  [31:0] bcTarget_reg;
   wire         timingValid_reg, excTake_reg, excPre_reg, frameValid_reg, resultWrite_reg;
   wire         traceExc_reg, accGrant_reg, bcHit_reg;
   int          nMismatch = 0, checked = 0, cycles = 0;

   fpet_exception_unit u_fpet_exception_unit (
      .ref_clk(ref_clk), .rst(rst), .issueValid(issueValid), .baseCycles(baseCycles),
      .baseReads(baseReads), .extOperand(extOperand), .srcFormat(srcFormat),
      .multiRegMove(multiRegMove), .memIndirect(memIndirect), .immOperand(immOperand),
      .doneValid(doneValid), .instrClass(instrClass), .inexactCond(inexactCond),
      .inexactEnable(inexactEnable), .snanCond(snanCond), .snanEnable(snanEnable),
      .operrCond(operrCond), .operrEnable(operrEnable), .srcSpecial(srcSpecial),
      .srcConverted(srcConverted), .srcRaw(srcRaw), .resultIn(resultIn),
      .traceStep(traceStep), .traceMode(traceMode), .accReq(accReq),
      .cacheModeField(cacheModeField), .accDone(accDone),
      .cacheControlWrite(cacheControlWrite), .cacheControlData(cacheControlData),
      .bcFill(bcFill), .bcFillAddr(bcFillAddr), .bcFillTarget(bcFillTarget),
      .bcLookupAddr(bcLookupAddr), .totalCycles_reg(totalCycles_reg),
      .totalReads_reg(totalReads_reg), .timingValid_reg(timingValid_reg),
      .excTake_reg(excTake_reg), .excPre_reg(excPre_reg), .excVector_reg(excVector_reg),
      .frameValid_reg(frameValid_reg), .frameClass_reg(frameClass_reg),
      .frameOperand_reg(frameOperand_reg), .resultWrite_reg(resultWrite_reg),
      .resultOut_reg(resultOut_reg), .traceExc_reg(traceExc_reg),
      .accGrant_reg(accGrant_reg), .bcHit_reg(bcHit_reg), .bcTarget_reg(bcTarget_reg)
   );

   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   // -----------------------------------------------------------------
   // Access tasks
   // -----------------------------------------------------------------
   task final_report;
      $display("checked %0d mismatches %0d", checked, nMismatch);
      if (nMismatch == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [79:0] e, input logic [79:0] g);
      checked++;
      if (g !== e) begin
         nMismatch++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task stp;
      @(posedge ref_clk);
      #1;
   endtask
   // Valid stays high between calls so consecutive issues go back to back
   task automatic iss(input logic [2:0] f, input logic e, m, mi, im, input logic [7:0] ac,
                      input logic [3:0] ar);
      baseCycles = baseCycles + 8'h07;
      {srcFormat, extOperand, multiRegMove, memIndirect, immOperand} = {f, e, m, mi, im};
      issueValid = 1;
      stp;
      chk("timingValid", 1, timingValid_reg);
      chk("totalCycles", baseCycles + ac, totalCycles_reg);
      chk("totalReads", baseReads + ar, totalReads_reg);
   endtask
   task automatic dn(input logic [1:0] cl, input logic [5:0] c, input logic sp, tk,
                     input logic [7:0] vec, input logic wr, raw);
      {inexactCond, inexactEnable, snanCond, snanEnable, operrCond, operrEnable} = c;
      {instrClass, srcSpecial, srcFormat, doneValid} = {cl, sp, 3'h1, 1'b1};
      stp;
      chk("excTake", tk, excTake_reg);
      chk("resultWrite", wr, resultWrite_reg);
      chk("resultOut", resultIn, resultOut_reg);
      if (tk) begin
         chk("excVector", vec, excVector_reg);
         chk("excPre", cl != 2'h3, excPre_reg);
         chk("frameClass", cl, frameClass_reg);
         chk("frameValid", 1, frameValid_reg);
         chk("frameOperand", raw ? srcRaw : srcConverted, frameOperand_reg);
      end
   endtask
   // Request is dropped in the cycle the grant shows
   task automatic acc(input logic [1:0] cm, input int n, input logic e);
      logic g = 0;
      stp;
      cacheModeField = cm;
      accReq = 1;
      for (int i = 0; i < n && !g; i++) begin
         stp;
         g = accGrant_reg;
      end
      accReq = 0;
      chk("accGrant", e, g);
   endtask
   task automatic trc(input logic [1:0] m, input logic e);
      traceMode = m;
      traceStep = 1;
      stp;
      traceStep = 0;
      chk("traceExc", e, traceExc_reg);
      stp;
   endtask
   task automatic look(input logic [31:0] a, input logic h);
      bcLookupAddr = a;
      stp;
      stp;
      chk("bcHit", h, bcHit_reg);
      if (h) chk("bcTarget", bcFillTarget, bcTarget_reg);
   endtask

   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 2000) begin
         nMismatch++;
         final_report;
      end
   end
   // -----------------------------------------------------------------
   // Tests
   // -----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge ref_clk);
      #1;
      rst = 0;
      iss(3'h6, 1, 0, 0, 0, 8'h03, 4'h0);
      iss(3'h4, 1, 0, 0, 0, 8'h03, 4'h0);
      iss(3'h0, 1, 0, 0, 0, 8'h03, 4'h0);
      iss(3'h2, 1, 0, 0, 0, 8'h02, 4'h0);
      iss(3'h2, 1, 1, 0, 0, 8'h00, 4'h0);
      iss(3'h1, 1, 0, 0, 0, 8'h00, 4'h0);
      iss(3'h1, 0, 0, 1, 0, 8'h02, 4'h1);
      iss(3'h6, 1, 0, 1, 0, 8'h05, 4'h1);
      iss(3'h5, 1, 0, 0, 1, 8'h01, 4'h0);
      iss(3'h1, 1, 0, 0, 1, 8'h00, 4'h0);
      issueValid = 0;
      chk("frameValid", 0, frameValid_reg);
      dn(2'h0, 6'b110000, 0, 1, 8'h31, 0, 0);
      dn(2'h2, 6'b110000, 0, 1, 8'h31, 0, 0);
      dn(2'h3, 6'b110000, 0, 1, 8'h31, 1, 0);
      dn(2'h3, 6'b100000, 0, 0, 8'h00, 1, 0);
      dn(2'h0, 6'b100000, 0, 0, 8'h00, 0, 0);
      dn(2'h3, 6'b001100, 0, 1, 8'h36, 0, 0);
      dn(2'h3, 6'b000011, 0, 1, 8'h34, 0, 0);
      dn(2'h2, 6'b001100, 1, 1, 8'h36, 0, 1);
      dn(2'h2, 6'b000011, 1, 1, 8'h34, 0, 1);
      dn(2'h2, 6'b111100, 0, 1, 8'h36, 0, 0);
      doneValid = 0;
      trc(2'h1, 0);
      trc(2'h2, 1);
      // Interrupt gating while locked belongs to system logic
      acc(2'h2, 6, 1);
      acc(2'h3, 4, 0);
      accDone = 1;
      stp;
      accDone = 0;
      acc(2'h3, 6, 1);
      {bcFillAddr, bcFillTarget, bcFill} = {32'h0000_1234, 32'hcafe_0010, 1'b1};
      stp;
      bcFill = 0;
      look(32'h0000_1234, 1);
      look(32'h0000_1274, 0);
      {cacheControlData, cacheControlWrite} = {32'h0000_0001, 1'b1};
      stp;
      cacheControlWrite = 0;
      look(32'h0000_1234, 1);
      {cacheControlData, cacheControlWrite} = {32'h0040_0000, 1'b1};
      stp;
      cacheControlWrite = 0;
      look(32'h0000_1234, 0);
      final_report;
   end
endmodule
